// ---- rtl/input_terminal_function_map.sv ----
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "input_terminal_function_map_defines.svh"

module input_terminal_function_map #(
    parameter int TERMINALS = 8
) (
    input wire logic ref_clk, // 50 MHz clock
    input wire logic rstn, // async reset, active low
    input wire input_terminal_function_map_pkg::wbReq_t wbReq, // wishbone request
    output logic [31:0] wbDatOut, // wishbone read data
    output logic wbAck, // wishbone acknowledge
    input wire logic [TERMINALS-1:0] terminalIn, // raw general terminal levels
    input wire logic forward_run_input, // raw forward-run terminal level
    output input_terminal_function_map_pkg::driveCmd_t drive, // decoded drive commands
    output logic irq // level interrupt
);
    import input_terminal_function_map_pkg::*;

    logic rstMeta;
    logic rstSync;
    logic [31:0] funcLow;
    logic [31:0] funcHigh;
    logic [TERMINALS:0] polarity;
    logic [`ITFM_EV_WIDTH-1:0] eventStatus;
    logic [`ITFM_EV_WIDTH-1:0] eventEnable;
    logic [TERMINALS-1:0] effPol;
    logic [TERMINALS-1:0] qualified;
    logic [TERMINALS-1:0][`ITFM_FUNC_WIDTH-1:0] funcCode;
    logic [63:0] funcHit;
    logic forwardAct;
    logic outsideTripPrev;
    logic outsideTripEdge;
    logic tripResetAct;
    logic runReq;
    logic busReq;
    logic wrStrobe;
    logic [`ITFM_EV_WIDTH-1:0] eventSet;
    logic [`ITFM_EV_WIDTH-1:0] clearMask;
    guardState_t guardState;
    guardState_t next_guardState;
    driveCmd_t next_drive;

    // address match helper used by read mux and write decode
    function automatic logic regHit(input logic [7:0] adr, input logic [7:0] ofs);
        regHit = (adr[7:2] == ofs[7:2]);
    endfunction

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    assign busReq = wbReq.cyc && wbReq.stb && !wbAck;
    assign wrStrobe = busReq && wbReq.we;

    // one wait state, ack drops the cycle after
    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= busReq;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            wbDatOut <= 32'h00000000;
        end else if (busReq && !wbReq.we) begin
            if (regHit(wbReq.adr, `ITFM_FUNC_LOW_OFS)) begin
                wbDatOut <= funcLow;
            end else if (regHit(wbReq.adr, `ITFM_FUNC_HIGH_OFS)) begin
                wbDatOut <= funcHigh;
            end else if (regHit(wbReq.adr, `ITFM_POLARITY_OFS)) begin
                wbDatOut <= {{(31-TERMINALS){1'b0}}, polarity};
            end else if (regHit(wbReq.adr, `ITFM_DRIVE_STATE_OFS)) begin
                wbDatOut <= {{(32-$bits(driveCmd_t)){1'b0}}, drive};
            end else if (regHit(wbReq.adr, `ITFM_EVENT_STATUS_OFS)) begin
                wbDatOut <= {{(32-`ITFM_EV_WIDTH){1'b0}}, eventStatus};
            end else if (regHit(wbReq.adr, `ITFM_EVENT_ENABLE_OFS)) begin
                wbDatOut <= {{(32-`ITFM_EV_WIDTH){1'b0}}, eventEnable};
            end else begin
                wbDatOut <= 32'h00000000;
            end
        end
    end

    // function assignment, byte lanes per terminal
    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            funcLow <= `ITFM_FUNC_LOW_RESET;
            funcHigh <= `ITFM_FUNC_HIGH_RESET;
        end else if (wrStrobe) begin
            for (int b = 0; b < 4; b++) begin
                if (wbReq.sel[b] && regHit(wbReq.adr, `ITFM_FUNC_LOW_OFS)) begin
                    funcLow[b*8 +: 8] <= {2'b00, wbReq.dat[b*8 +: 6]};
                end
                if (wbReq.sel[b] && regHit(wbReq.adr, `ITFM_FUNC_HIGH_OFS)) begin
                    funcHigh[b*8 +: 8] <= {2'b00, wbReq.dat[b*8 +: 6]};
                end
            end
        end
    end

    // polarity bits, forward terminal in the top bit
    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            polarity <= `ITFM_POLARITY_RESET;
        end else if (wrStrobe && regHit(wbReq.adr, `ITFM_POLARITY_OFS)) begin
            if (wbReq.sel[0]) begin
                polarity[7:0] <= wbReq.dat[7:0];
            end
            if (wbReq.sel[1]) begin
                polarity[`ITFM_POL_FORWARD_BIT] <= wbReq.dat[`ITFM_POL_FORWARD_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            eventEnable <= '0;
        end else if (wrStrobe && wbReq.sel[0] && regHit(wbReq.adr, `ITFM_EVENT_ENABLE_OFS)) begin
            eventEnable <= wbReq.dat[`ITFM_EV_WIDTH-1:0];
        end
    end

    // polarity qualification per terminal
    genvar t;
    generate
        for (t = 0; t < TERMINALS; t++) begin : gTerm
            assign funcCode[t] = (t < 4) ? funcLow[(t%4)*8 +: `ITFM_FUNC_WIDTH]
                                         : funcHigh[(t%4)*8 +: `ITFM_FUNC_WIDTH];
            // trip reset terminal is forced to normally open
            assign effPol[t] = polarity[t] && (funcCode[t] != `ITFM_OPT_TRIP_RESET);
            assign qualified[t] = terminalIn[t] ^ effPol[t];

            a_reset_no_closed: assert property (@(posedge ref_clk) disable iff (!rstSync)
                (funcCode[t] == `ITFM_OPT_TRIP_RESET) |-> (qualified[t] == terminalIn[t]))
                else $error("trip reset terminal not normally open");

            a_terminal_hit: assert property (@(posedge ref_clk) disable iff (!rstSync)
                qualified[t] |-> funcHit[funcCode[t]])
                else $error("active terminal did not raise its function");
        end
    endgenerate

    assign forwardAct = forward_run_input ^ polarity[`ITFM_POL_FORWARD_BIT];

    // or of every terminal assigned to a code
    always_comb begin
        funcHit = 64'h0000000000000000;
        for (int i = 0; i < TERMINALS; i++) begin
            funcHit[funcCode[i]] = funcHit[funcCode[i]] | qualified[i];
        end
    end

    assign tripResetAct = funcHit[`ITFM_OPT_TRIP_RESET];
    assign runReq = forwardAct || funcHit[`ITFM_OPT_REVERSE] || funcHit[`ITFM_OPT_JOG];

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            outsideTripPrev <= 1'b0;
        end else begin
            outsideTripPrev <= funcHit[`ITFM_OPT_OUTSIDE_TRIP];
        end
    end

    assign outsideTripEdge = funcHit[`ITFM_OPT_OUTSIDE_TRIP] && !outsideTripPrev;

    // start guard: judged once after power-up or trip reset
    always_comb begin
        next_guardState = guardState;
        case (guardState)
            GUARD_ARMED: begin
                if (funcHit[`ITFM_OPT_START_GUARD] && runReq) begin
                    next_guardState = GUARD_BLOCKED;
                end else begin
                    next_guardState = GUARD_IDLE;
                end
            end
            GUARD_BLOCKED: begin
                if (!runReq) begin
                    next_guardState = GUARD_IDLE;
                end
            end
            GUARD_IDLE: begin
                next_guardState = GUARD_IDLE;
            end
            default: begin
                next_guardState = GUARD_ARMED;
            end
        endcase
        if (tripResetAct) begin
            next_guardState = GUARD_ARMED;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            guardState <= GUARD_ARMED;
        end else begin
            guardState <= next_guardState;
        end
    end

    // command decode
    always_comb begin
        next_drive = drive;
        next_drive.forwardRun = forwardAct;
        next_drive.reverseRun = funcHit[`ITFM_OPT_REVERSE];
        next_drive.speedSelect = {funcHit[`ITFM_OPT_SPEED_BIT3], funcHit[`ITFM_OPT_SPEED_BIT2],
                                  funcHit[`ITFM_OPT_SPEED_BIT1], funcHit[`ITFM_OPT_SPEED_BIT0]};
        next_drive.jogRun = funcHit[`ITFM_OPT_JOG];
        next_drive.dcBrake = funcHit[`ITFM_OPT_DC_BRAKE];
        next_drive.secondMotor = funcHit[`ITFM_OPT_SECOND_MOTOR];
        next_drive.secondRamp = funcHit[`ITFM_OPT_SECOND_RAMP];
        next_drive.coastStop = funcHit[`ITFM_OPT_COAST_STOP];
        next_drive.powerupReset = tripResetAct;
        next_drive.startBlocked = (next_guardState == GUARD_BLOCKED);
        // a new trip edge wins over a reset in the same cycle
        if (outsideTripEdge) begin
            next_drive.tripLatched = 1'b1;
            next_drive.tripCode = `ITFM_ERR_OUTSIDE_TRIP;
        end else if (tripResetAct) begin
            next_drive.tripLatched = 1'b0;
            next_drive.tripCode = `ITFM_ERR_NONE;
        end
        next_drive.motorOn = runReq && !funcHit[`ITFM_OPT_COAST_STOP] && !tripResetAct
                             && !next_drive.tripLatched && !next_drive.startBlocked;
    end

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            drive <= '0;
        end else begin
            drive <= next_drive;
        end
    end

    // sticky events, set wins over clear
    assign eventSet = {(next_guardState == GUARD_BLOCKED) && (guardState == GUARD_ARMED),
                       tripResetAct, outsideTripEdge};
    assign clearMask = (wrStrobe && wbReq.sel[0] && regHit(wbReq.adr, `ITFM_EVENT_CLEAR_OFS))
                       ? wbReq.dat[`ITFM_EV_WIDTH-1:0] : '0;

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            eventStatus <= '0;
        end else begin
            eventStatus <= (eventStatus & ~clearMask) | eventSet;
        end
    end

    assign irq = |(eventStatus & eventEnable);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstSync);

    a_ack_single_pulse: assert property (wbAck |=> !wbAck)
        else $error("ack held more than one cycle");
    a_ack_after_req: assert property (busReq |=> wbAck)
        else $error("request not acknowledged in one cycle");
    a_trip_latch_edge: assert property (outsideTripEdge |=> drive.tripLatched && drive.tripCode == 8'h0c)
        else $error("outside trip edge not latched with code");
    a_trip_stays: assert property (drive.tripLatched && !tripResetAct |=> drive.tripLatched)
        else $error("trip dropped without reset");
    a_reset_clears_trip: assert property (tripResetAct && !outsideTripEdge
        |=> !drive.tripLatched && !drive.motorOn && drive.powerupReset)
        else $error("trip reset did not clear and stop");
    a_coast_output_off: assert property (funcHit[`ITFM_OPT_COAST_STOP] |=> !drive.motorOn)
        else $error("motor on during coast stop");
    a_reverse_runs: assert property (funcHit[`ITFM_OPT_REVERSE] && !funcHit[`ITFM_OPT_COAST_STOP]
        && !tripResetAct && !drive.tripLatched && !outsideTripEdge && guardState == GUARD_IDLE
        |=> drive.reverseRun && drive.motorOn)
        else $error("reverse command did not run motor");
    a_jog_runs: assert property (funcHit[`ITFM_OPT_JOG] |=> drive.jogRun)
        else $error("jog command not passed");
    a_speed_bits: assert property (1'b1 |=> drive.speedSelect == {$past(funcHit[`ITFM_OPT_SPEED_BIT3]),
        $past(funcHit[`ITFM_OPT_SPEED_BIT2]), $past(funcHit[`ITFM_OPT_SPEED_BIT1]),
        $past(funcHit[`ITFM_OPT_SPEED_BIT0])})
        else $error("speed select bits misordered");
    a_brake_select: assert property (1'b1 |=> drive.dcBrake == $past(funcHit[7])
        && drive.secondMotor == $past(funcHit[8]) && drive.secondRamp == $past(funcHit[9]))
        else $error("brake or second set select wrong");
    a_guard_blocks: assert property (guardState == GUARD_ARMED && funcHit[13] && runReq && !tripResetAct
        |=> drive.startBlocked && !drive.motorOn)
        else $error("power-up run not blocked");
    a_irq_event: assert property (outsideTripEdge && eventEnable[`ITFM_EV_TRIP] |=> irq)
        else $error("enabled event raised no interrupt");

    a_ack_only_on_req: assert property (!busReq |=> !wbAck)
        else $error("ack without a request");
    a_trip_sets_status: assert property (outsideTripEdge |=> eventStatus[`ITFM_EV_TRIP])
        else $error("trip event lost against clear");
    a_trip_code_kept: assert property (drive.tripLatched |-> drive.tripCode == `ITFM_ERR_OUTSIDE_TRIP)
        else $error("trip latched with wrong code");
    a_forward_sense: assert property (1'b1 |=> drive.forwardRun
        == ($past(forward_run_input) ^ $past(polarity[`ITFM_POL_FORWARD_BIT])))
        else $error("forward terminal polarity not applied");
    a_no_run_no_motor: assert property (!runReq |=> !drive.motorOn)
        else $error("motor on without run request");
    a_run_flags: assert property (1'b1 |=> drive.reverseRun == $past(funcHit[`ITFM_OPT_REVERSE])
        && drive.jogRun == $past(funcHit[`ITFM_OPT_JOG]))
        else $error("reverse or jog flag wrong");
    a_coast_flag: assert property (1'b1 |=> drive.coastStop == $past(funcHit[`ITFM_OPT_COAST_STOP]))
        else $error("coast flag wrong");
    a_powerup_level: assert property (1'b1 |=> drive.powerupReset == $past(tripResetAct))
        else $error("power-up reset not following trip reset");
    a_guard_release: assert property (guardState == GUARD_BLOCKED && !runReq && !tripResetAct
        |=> !drive.startBlocked && guardState == GUARD_IDLE)
        else $error("start guard not released");
    a_status_sticky: assert property (eventStatus[`ITFM_EV_TRIP_RESET] && !clearMask[`ITFM_EV_TRIP_RESET]
        |=> eventStatus[`ITFM_EV_TRIP_RESET])
        else $error("trip reset event dropped without clear");

    c_outside_trip: cover property (outsideTripEdge ##1 drive.tripLatched);
    c_start_blocked: cover property (guardState == GUARD_BLOCKED ##[1:20] guardState == GUARD_IDLE);
    c_top_speed: cover property (drive.speedSelect == 4'hf && drive.motorOn);
    c_irq_raised: cover property ($rose(irq));
    c_trip_cleared: cover property (drive.tripLatched ##1 tripResetAct ##1 !drive.tripLatched);

endmodule

// ---- inc/input_terminal_function_map_defines.svh ----
`ifndef INPUT_TERMINAL_FUNCTION_MAP_DEFINES_SVH
`define INPUT_TERMINAL_FUNCTION_MAP_DEFINES_SVH

// register byte offsets
`define ITFM_FUNC_LOW_OFS 8'h00
`define ITFM_FUNC_HIGH_OFS 8'h04
`define ITFM_POLARITY_OFS 8'h08
`define ITFM_DRIVE_STATE_OFS 8'h0c
`define ITFM_EVENT_STATUS_OFS 8'h10
`define ITFM_EVENT_CLEAR_OFS 8'h14
`define ITFM_EVENT_ENABLE_OFS 8'h18

// option codes
`define ITFM_OPT_REVERSE 6'h01
`define ITFM_OPT_SPEED_BIT0 6'h02
`define ITFM_OPT_SPEED_BIT1 6'h03
`define ITFM_OPT_SPEED_BIT2 6'h04
`define ITFM_OPT_SPEED_BIT3 6'h05
`define ITFM_OPT_JOG 6'h06
`define ITFM_OPT_DC_BRAKE 6'h07
`define ITFM_OPT_SECOND_MOTOR 6'h08
`define ITFM_OPT_SECOND_RAMP 6'h09
`define ITFM_OPT_COAST_STOP 6'h0b
`define ITFM_OPT_OUTSIDE_TRIP 6'h0c
`define ITFM_OPT_START_GUARD 6'h0d
`define ITFM_OPT_TRIP_RESET 6'h12

// polarity codes: bit value 0 = normally open, 1 = normally closed
`define ITFM_POL_NORMALLY_OPEN 1'b0
`define ITFM_POL_NORMALLY_CLOSED 1'b1
`define ITFM_POLARITY_RESET 9'h000
`define ITFM_POL_FORWARD_BIT 8

// function assignment reset values, one byte per terminal
`define ITFM_FUNC_LOW_RESET 32'h0b061012
`define ITFM_FUNC_HIGH_RESET 32'h01020309
`define ITFM_FUNC_WIDTH 6

// trip code shown for an outside trip
`define ITFM_ERR_OUTSIDE_TRIP 8'h0c
`define ITFM_ERR_NONE 8'h00

// event status bit positions
`define ITFM_EV_TRIP 0
`define ITFM_EV_TRIP_RESET 1
`define ITFM_EV_START_BLOCKED 2
`define ITFM_EV_WIDTH 3

`endif

// ---- inc/input_terminal_function_map_pkg.sv ----
package input_terminal_function_map_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wbReq_t;

    typedef struct packed {
        logic motorOn;
        logic forwardRun;
        logic reverseRun;
        logic [3:0] speedSelect;
        logic jogRun;
        logic dcBrake;
        logic secondMotor;
        logic secondRamp;
        logic coastStop;
        logic tripLatched;
        logic [7:0] tripCode;
        logic powerupReset;
        logic startBlocked;
    } driveCmd_t;

    typedef enum logic [1:0] {
        GUARD_ARMED = 2'b00,
        GUARD_IDLE = 2'b01,
        GUARD_BLOCKED = 2'b10
    } guardState_t;

endpackage

// ---- verif/terminal_contacts.sv ----
`timescale 1ns/1ps

module terminal_contacts (
    input wire logic ref_clk, // bench clock
    input wire logic [8:0] closed, // commanded contacts, bit8 forward
    input wire logic [3:0] settle, // cycles before a change shows
    output logic [7:0] terminalIn = 8'h00, // general terminal levels
    output logic forward_run_input = 1'b0 // forward terminal level
);
    logic [3:0] waitCnt = 4'h0;

    // closed contact pulls its terminal high; slow contacts lag by settle cycles
    always @(posedge ref_clk) begin
        if ({forward_run_input, terminalIn} == closed) begin
            waitCnt <= 4'h0;
        end else if (waitCnt >= settle) begin
            {forward_run_input, terminalIn} <= closed;
            waitCnt <= 4'h0;
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "input_terminal_function_map_defines.svh"

module testbench;
    import input_terminal_function_map_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    wbReq_t wbReq = '0;
    logic [31:0] wbDatOut;
    logic wbAck;
    logic [7:0] terminalIn;
    logic forward_run_input;
    driveCmd_t drive;
    logic irq;
    logic [8:0] closed = 9'h000;
    logic [3:0] settle = 4'h0;
    int failures = 0;
    int n_checks = 0;

    always #10 ref_clk = ~ref_clk;

    input_terminal_function_map input_terminal_function_map_i (.ref_clk(ref_clk), .rstn(rstn), .wbReq(wbReq),
        .wbDatOut(wbDatOut), .wbAck(wbAck), .terminalIn(terminalIn), .forward_run_input(forward_run_input),
        .drive(drive), .irq(irq));
    terminal_contacts terminal_contacts_i (.ref_clk(ref_clk), .closed(closed), .settle(settle),
        .terminalIn(terminalIn), .forward_run_input(forward_run_input));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int i;
        @(posedge ref_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (wbAck === 1'b1) break;
        end
        rd = wbDatOut;
        wbReq <= '0;
        if (i == 20) begin
            failures++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] rd;
        wbXfer(1'b1, adr, dat, rd);
    endtask

    task automatic rdChk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wbXfer(1'b0, adr, 32'h0, rd);
        check(what, rd, exp);
    endtask

    task automatic contacts(input logic [8:0] c);
        @(posedge ref_clk);
        closed <= c;
        repeat (5 + int'(settle)) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic pick(input logic [5:0] c);
        case (c)
            6'h01: pick = drive.reverseRun;
            6'h02: pick = drive.speedSelect[0];
            6'h03: pick = drive.speedSelect[1];
            6'h04: pick = drive.speedSelect[2];
            6'h05: pick = drive.speedSelect[3];
            6'h06: pick = drive.jogRun;
            6'h07: pick = drive.dcBrake;
            6'h08: pick = drive.secondMotor;
            6'h09: pick = drive.secondRamp;
            default: pick = drive.coastStop;
        endcase
    endfunction

    task automatic resetValues;
        rdChk("func low", `ITFM_FUNC_LOW_OFS, `ITFM_FUNC_LOW_RESET);
        rdChk("func high", `ITFM_FUNC_HIGH_OFS, `ITFM_FUNC_HIGH_RESET);
        rdChk("polarity", `ITFM_POLARITY_OFS, 32'h0);
        rdChk("enable", `ITFM_EVENT_ENABLE_OFS, 32'h0);
        rdChk("unmapped", 8'h1c, 32'h0);
    endtask

    task automatic decodeAll;
        logic [5:0] codes [10] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0b};
        foreach (codes[k]) begin
            wr(`ITFM_FUNC_HIGH_OFS, {10'h0, codes[k], 16'h0});
            contacts(9'h040);
            check("function on", 32'(pick(codes[k])), 32'h1);
            check("motor on", 32'(drive.motorOn), 32'((codes[k] == 6'h01) || (codes[k] == 6'h06)));
            contacts(9'h000);
            check("function off", 32'(pick(codes[k])), 32'h0);
        end
    endtask

    task automatic speedAndOr;
        settle = 4'h3;
        wr(`ITFM_FUNC_HIGH_OFS, 32'h05040302);
        contacts(9'h0b0);
        check("speed select", 32'(drive.speedSelect), 32'hb);
        wr(`ITFM_FUNC_HIGH_OFS, 32'h00000707);
        contacts(9'h020);
        check("shared brake", 32'(drive.dcBrake), 32'h1);
        contacts(9'h010);
        check("shared brake t5", 32'(drive.dcBrake), 32'h1);
        settle = 4'h0;
        contacts(9'h000);
    endtask

    task automatic polarity;
        wr(`ITFM_FUNC_HIGH_OFS, 32'h00000008);
        wr(`ITFM_POLARITY_OFS, 32'h110);
        contacts(9'h000);
        check("closed sense t5", 32'(drive.secondMotor), 32'h1);
        check("closed sense fwd", 32'(drive.forwardRun), 32'h1);
        contacts(9'h110);
        check("closed sense fwd off", 32'(drive.forwardRun | drive.secondMotor), 32'h0);
        wr(`ITFM_POLARITY_OFS, 32'h001);
        contacts(9'h000);
        check("reset stays open", 32'(drive.powerupReset), 32'h0);
        wr(`ITFM_POLARITY_OFS, 32'h000);
    endtask

    task automatic tripAndReset;
        wr(`ITFM_EVENT_ENABLE_OFS, 32'h1);
        wr(`ITFM_FUNC_LOW_OFS, 32'h0b060c12);
        contacts(9'h102);
        check("trip code", 32'({drive.tripLatched, drive.tripCode}), 32'h10c);
        check("trip motor", 32'({drive.motorOn, irq}), 32'h1);
        contacts(9'h100);
        check("trip sticky", 32'(drive.tripLatched), 32'h1);
        rdChk("trip event", `ITFM_EVENT_STATUS_OFS, 32'h1);
        wr(`ITFM_EVENT_CLEAR_OFS, 32'h1);
        #1;
        check("irq cleared", 32'(irq), 32'h0);
        contacts(9'h101);
        check("trip reset", 32'({drive.tripLatched, drive.tripCode, drive.motorOn, drive.powerupReset}), 32'h1);
        contacts(9'h100);
        check("run after reset", 32'(drive.motorOn), 32'h1);
    endtask

    task automatic startGuard;
        wr(`ITFM_FUNC_LOW_OFS, 32'h0b060d12);
        contacts(9'h103);
        contacts(9'h102);
        check("start blocked", 32'({drive.startBlocked, drive.motorOn}), 32'h2);
        rdChk("drive state", `ITFM_DRIVE_STATE_OFS, 32'h00200001);
        rdChk("guard event", `ITFM_EVENT_STATUS_OFS, 32'h6);
        contacts(9'h002);
        check("guard released", 32'(drive.startBlocked), 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        resetValues();
        decodeAll();
        speedAndOr();
        polarity();
        tripAndReset();
        startGuard();
        print_verdict();
    end
endmodule
